// file: rtl/pdd_map.svh
/*
 * Address map, reset values and bit masks of the port direction/data block.
 * Assumes it is included by bare name, before use.
 */
`ifndef PDD_MAP_SVH
`define PDD_MAP_SVH

// Byte addresses on the CPU data bus
`define PDD_ADDR_DAT0      20'hf_ff00
`define PDD_ADDR_DAT1      20'hf_ff01
`define PDD_ADDR_DAT4      20'hf_ff04
`define PDD_ADDR_IN12      20'hf_ff0c
`define PDD_ADDR_IN13      20'hf_ff0d
`define PDD_ADDR_DIR0      20'hf_ff20
`define PDD_ADDR_DIR1      20'hf_ff21
`define PDD_ADDR_DIR4      20'hf_ff24

// Reset values
`define PDD_DIR_RST        8'hff
`define PDD_LAT_RST        8'h00
`define PDD_ZERO           8'h00

// Implemented bits of each port
`define PDD_IMPL_0         8'hff
`define PDD_IMPL_1         8'h7f
`define PDD_IMPL_4         8'h01
`define PDD_IMPL_12        8'h20
`define PDD_IMPL_13        8'h80

// Pins that have an analog select
`define PDD_ANA_0          8'h80
`define PDD_ANA_1          8'h7f

// Bit positions of the two input-only pins
`define PDD_RST_PIN_BIT    5
`define PDD_TMR_PIN_BIT    7

`endif

// file: rtl/pdd_pkg.sv
/*
 * Types of the port direction/data block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pdd_pkg;

    // Complete state of the top module
    typedef struct packed {
        logic [7:0] dir0;
        logic [7:0] dir1;
        logic [7:0] dir4;
        logic [7:0] lat0;
        logic [7:0] lat1;
        logic [7:0] lat4;
        logic [7:0] oe0;
        logic [7:0] oe1;
        logic [7:0] oe4;
        logic [7:0] pu0;
        logic [7:0] pu1;
        logic [7:0] pu4;
        logic [7:0] pu12;
        logic [7:0] rdata;
    } pdd_state_type;

endpackage

// file: rtl/pdd_rd_if.sv
/*
 * Carries one port's direction, latch, pin and analog bits to the read
 * selector and its read value back.
 * Assumes one instance per port inside the top module.
 */
`timescale 1ns/1ps

interface pdd_rd_if;
    logic [7:0] dir;
    logic [7:0] latch;
    logic [7:0] pin;
    logic [7:0] analog;
    logic [7:0] value;

    modport regs (output dir, output latch, output pin, output analog, input value);
    modport mux  (input dir, input latch, input pin, input analog, output value);
endinterface

// file: rtl/pdd_read_mux.sv
/*
 * Read value of one bidirectional port.
 * Assumes the inputs come from registers or synchronous pins.
 */
`timescale 1ns/1ps

module pdd_read_mux
    import pdd_pkg::*;
#(
    parameter logic [7:0] IMPL = 8'hff
)(
    pdd_rd_if.mux rd
);

    // Input mode shows the pin, output mode the latch; analog pins in input mode read 0
    always_comb
    begin
        rd.value = IMPL & ((rd.dir & ~rd.analog & rd.pin) | (~rd.dir & rd.latch)); // see (R5) see (R7) see (R13)
    end

endmodule // pdd_read_mux

// file: rtl/pdd_port_regs.sv
/*
 * Direction and data registers of ports 0, 1, 4 and input registers of
 * ports 12 and 13, on the CPU byte/bit bus.
 * Assumes pins, bus and mode inputs are synchronous to clk.
 */
//Contract
//(R1) Direction 0 drives pin, 1 floats
//(R2) Reset sets all direction registers ones
//(R3) Byte and single-bit writes both accepted
//(R4) Data write loads latch driving output pins
//(R5) Read: input mode pin, output mode latch
//(R6) Reset clears latches; input ports undefined
//(R7) Analog input pins always read zero
//(R8) Reset-function shared pin reads one
//(R9) Software writes fixed bits at reset value
//(R10) Software sets direction before alternate use
//(R11) Data 0 low, 1 high, both ways
//(R12) Pull-up only input, digital, normal output
//(R13) One byte each; fixed bits stay fixed
`timescale 1ns/1ps
`include "pdd_map.svh"

module pdd_port_regs
    import pdd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [19:0] bus_addr,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    input  wire logic        bus_bit_op,
    input  wire logic [2:0]  bus_bit_idx,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    input  wire logic [7:0]  port0_in,
    input  wire logic [7:0]  port1_in,
    input  wire logic [7:0]  port4_in,
    input  wire logic        reset_shared_pin,
    input  wire logic        timer_interrupt_input_pin,
    input  wire logic        reset_pin_select,
    input  wire logic [7:0]  analog_select_bit0,
    input  wire logic [7:0]  analog_select_bit1,
    input  wire logic [7:0]  pullup_enable_bit0,
    input  wire logic [7:0]  pullup_enable_bit1,
    input  wire logic [7:0]  pullup_enable_bit4,
    input  wire logic        pullup_enable_bit12,
    input  wire logic [7:0]  output_style_bit0,
    input  wire logic [7:0]  output_style_bit1,
    output logic      [7:0]  port0_out,
    output logic      [7:0]  port1_out,
    output logic      [7:0]  port4_out,
    output logic      [7:0]  port0_oe,
    output logic      [7:0]  port1_oe,
    output logic      [7:0]  port4_oe,
    output logic      [7:0]  pullup_on0,
    output logic      [7:0]  pullup_on1,
    output logic      [7:0]  pullup_on4,
    output logic             pullup_on12
);

    ////////////////////////////////////////////////////////////////////////
    // State and constants

    localparam pdd_state_type RST_STATE = '{
        dir0: `PDD_DIR_RST, dir1: `PDD_DIR_RST, dir4: `PDD_DIR_RST,
        lat0: `PDD_LAT_RST, lat1: `PDD_LAT_RST, lat4: `PDD_LAT_RST,
        oe0: `PDD_ZERO, oe1: `PDD_ZERO, oe4: `PDD_ZERO,
        pu0: `PDD_ZERO, pu1: `PDD_ZERO, pu4: `PDD_ZERO, pu12: `PDD_ZERO,
        rdata: `PDD_ZERO
    };

    pdd_state_type st_ff;
    pdd_state_type nxt_st;
    logic [7:0]    ana0;
    logic [7:0]    ana1;
    logic [7:0]    rd_in12;
    logic [7:0]    rd_in13;
    logic [7:0]    rd_val;

    // Merge a byte or single-bit write; fixed bits always return to their value
    function automatic logic [7:0] wr_merge(
        input logic [7:0] old,
        input logic [7:0] wd,
        input logic       bit_op,
        input logic [2:0] idx,
        input logic [7:0] impl,
        input logic [7:0] fixval
    );
        logic [7:0] v;
        v = old;
        if (bit_op)
        begin
            v[idx] = wd[0];                              // see (R3)
        end
        else
        begin
            v = wd;                                      // see (R3)
        end
        return (v & impl) | (fixval & ~impl);            // see (R13)
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Read selectors of the three bidirectional ports

    pdd_rd_if u_if0 ();
    pdd_rd_if u_if1 ();
    pdd_rd_if u_if4 ();

    // Analog select exists only on some pins; others never read as analog
    assign ana0 = analog_select_bit0 & `PDD_ANA_0;
    assign ana1 = analog_select_bit1 & `PDD_ANA_1;

    assign u_if0.dir    = st_ff.dir0;
    assign u_if0.latch  = st_ff.lat0;
    assign u_if0.pin    = port0_in;
    assign u_if0.analog = ana0;
    assign u_if1.dir    = st_ff.dir1;
    assign u_if1.latch  = st_ff.lat1;
    assign u_if1.pin    = port1_in;
    assign u_if1.analog = ana1;
    assign u_if4.dir    = st_ff.dir4;
    assign u_if4.latch  = st_ff.lat4;
    assign u_if4.pin    = port4_in;
    assign u_if4.analog = `PDD_ZERO;

    pdd_read_mux #(.IMPL(`PDD_IMPL_0)) u_mux0 (.rd(u_if0.mux));
    pdd_read_mux #(.IMPL(`PDD_IMPL_1)) u_mux1 (.rd(u_if1.mux));
    pdd_read_mux #(.IMPL(`PDD_IMPL_4)) u_mux4 (.rd(u_if4.mux));

    // Input-only ports; the shared pin reads 1 while it is the reset input
    always_comb
    begin
        rd_in12 = `PDD_ZERO;
        rd_in13 = `PDD_ZERO;
        rd_in12[`PDD_RST_PIN_BIT] = reset_pin_select | reset_shared_pin;   // see (R8)
        rd_in13[`PDD_TMR_PIN_BIT] = timer_interrupt_input_pin;
    end

    // Byte read decode; unmapped addresses read zero
    always_comb
    begin
        case (bus_addr)
            `PDD_ADDR_DAT0: rd_val = u_if0.value;        // see (R5)
            `PDD_ADDR_DAT1: rd_val = u_if1.value;
            `PDD_ADDR_DAT4: rd_val = u_if4.value;
            `PDD_ADDR_IN12: rd_val = rd_in12;
            `PDD_ADDR_IN13: rd_val = rd_in13;
            `PDD_ADDR_DIR0: rd_val = st_ff.dir0;
            `PDD_ADDR_DIR1: rd_val = st_ff.dir1;
            `PDD_ADDR_DIR4: rd_val = st_ff.dir4;
            default:        rd_val = `PDD_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: writes, read capture, pin drive, pull-ups

    always_comb
    begin
        nxt_st = st_ff;
        if (ce)
        begin
            if (bus_wr)
            begin
                // Writes to input-only or unmapped addresses are dropped
                case (bus_addr)
                    `PDD_ADDR_DAT0:    nxt_st.lat0 = wr_merge(st_ff.lat0, bus_wdata, bus_bit_op, bus_bit_idx,
                                                              `PDD_IMPL_0, `PDD_LAT_RST); // see (R4)
                    `PDD_ADDR_DAT1:    nxt_st.lat1 = wr_merge(st_ff.lat1, bus_wdata, bus_bit_op, bus_bit_idx,
                                                              `PDD_IMPL_1, `PDD_LAT_RST); // see (R4)
                    `PDD_ADDR_DAT4:    nxt_st.lat4 = wr_merge(st_ff.lat4, bus_wdata, bus_bit_op, bus_bit_idx,
                                                              `PDD_IMPL_4, `PDD_LAT_RST); // see (R4)
                    `PDD_ADDR_DIR0:    nxt_st.dir0 = wr_merge(st_ff.dir0, bus_wdata, bus_bit_op, bus_bit_idx,
                                                              `PDD_IMPL_0, `PDD_DIR_RST); // see (R1)
                    `PDD_ADDR_DIR1:    nxt_st.dir1 = wr_merge(st_ff.dir1, bus_wdata, bus_bit_op, bus_bit_idx,
                                                              `PDD_IMPL_1, `PDD_DIR_RST); // see (R1)
                    `PDD_ADDR_DIR4:    nxt_st.dir4 = wr_merge(st_ff.dir4, bus_wdata, bus_bit_op, bus_bit_idx,
                                                              `PDD_IMPL_4, `PDD_DIR_RST); // see (R1)
                    default:           nxt_st.rdata = st_ff.rdata;
                endcase
            end
            // Read sees the state before a same-cycle write
            if (bus_rd)
            begin
                nxt_st.rdata = rd_val;
            end
            // Buffer on where the direction bit is 0
            nxt_st.oe0 = ~nxt_st.dir0;                   // see (R1) see (R11)
            nxt_st.oe1 = ~nxt_st.dir1;                   // see (R1)
            nxt_st.oe4 = ~nxt_st.dir4;                   // see (R1)
            // Pull-up needs input mode, digital use and normal output style
            nxt_st.pu0 = pullup_enable_bit0 & nxt_st.dir0 & ~ana0 & ~output_style_bit0;         // see (R12)
            nxt_st.pu1 = pullup_enable_bit1 & nxt_st.dir1 & ~ana1 & ~output_style_bit1 & `PDD_IMPL_1; // see (R12)
            nxt_st.pu4 = pullup_enable_bit4 & nxt_st.dir4 & `PDD_IMPL_4;                      // see (R12)
            // The reset-function pin keeps its pull-up whatever software sets
            nxt_st.pu12 = `PDD_ZERO;
            nxt_st.pu12[`PDD_RST_PIN_BIT] = pullup_enable_bit12 | reset_pin_select;
        end
        // Reset wins over the clock enable
        if (!rst_n)
        begin
            nxt_st = RST_STATE;                          // see (R2) see (R6)
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        st_ff <= nxt_st;
    end

    // Outputs straight from the state register
    assign bus_rdata   = st_ff.rdata;
    assign port0_out   = st_ff.lat0;                     // see (R4) see (R11)
    assign port1_out   = st_ff.lat1;
    assign port4_out   = st_ff.lat4;
    assign port0_oe    = st_ff.oe0;
    assign port1_oe    = st_ff.oe1;
    assign port4_oe    = st_ff.oe4;
    assign pullup_on0  = st_ff.pu0;
    assign pullup_on1  = st_ff.pu1;
    assign pullup_on4  = st_ff.pu4;
    assign pullup_on12 = st_ff.pu12[`PDD_RST_PIN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_reset_dir_latch: assert property ($rose(rst_n) |-> st_ff.dir0 == `PDD_DIR_RST && st_ff.dir1 == `PDD_DIR_RST // see (R2) see (R6)
        && st_ff.dir4 == `PDD_DIR_RST && st_ff.lat0 == `PDD_LAT_RST && port0_oe == `PDD_ZERO)
        else $error("direction or latch not at reset value");
    a_oe_from_dir: assert property (port1_oe == ~st_ff.dir1 && port0_oe == ~st_ff.dir0) // see (R1)
        else $error("output enable disagrees with direction");
    a_byte_write_out: assert property (ce && bus_wr && !bus_bit_op && bus_addr == `PDD_ADDR_DAT0 // see (R4)
        |=> port0_out == $past(bus_wdata))
        else $error("byte write did not reach port 0 pins");
    a_bit_write_one: assert property (ce && bus_wr && bus_bit_op && bus_addr == `PDD_ADDR_DIR0 // see (R3)
        |=> st_ff.dir0[$past(bus_bit_idx)] == $past(bus_wdata[0])
            && ((st_ff.dir0 ^ $past(st_ff.dir0)) & ~(8'h01 << $past(bus_bit_idx))) == `PDD_ZERO)
        else $error("bit write touched other bits or missed");
    a_read_pin_input: assert property (ce && bus_rd && bus_addr == `PDD_ADDR_DAT0 && st_ff.dir0 == `PDD_DIR_RST // see (R5)
        && ana0 == `PDD_ZERO |=> bus_rdata == $past(port0_in))
        else $error("input mode read is not the pin level");
    // Bit 7 of the port 1 direction is fixed at 1, so only implemented bits decide output mode
    a_read_latch_out: assert property (ce && bus_rd && bus_addr == `PDD_ADDR_DAT1 // see (R5)
        && (st_ff.dir1 & `PDD_IMPL_1) == `PDD_ZERO |=> bus_rdata == $past(st_ff.lat1))
        else $error("output mode read is not the latch");
    a_analog_reads_zero: assert property (ce && bus_rd && bus_addr == `PDD_ADDR_DAT0 && ana0[7] && st_ff.dir0[7] // see (R7)
        |=> !bus_rdata[7])
        else $error("analog pin read nonzero");
    a_reset_pin_one: assert property (ce && bus_rd && bus_addr == `PDD_ADDR_IN12 && reset_pin_select // see (R8)
        |=> bus_rdata == `PDD_IMPL_12)
        else $error("reset-function pin read not one");
    a_fixed_bits_hold: assert property ((st_ff.dir4 | `PDD_IMPL_4) == `PDD_DIR_RST // see (R13)
        && (st_ff.lat1 & ~`PDD_IMPL_1) == `PDD_ZERO && (st_ff.dir1 | `PDD_IMPL_1) == `PDD_DIR_RST)
        else $error("fixed bit changed");
    a_pullup_gate: assert property (ce && !bus_wr ##1 1 |-> pullup_on0 == $past(pullup_enable_bit0 & st_ff.dir0 // see (R12)
        & ~ana0 & ~output_style_bit0))
        else $error("pull-up gating wrong");
    a_freeze_ce: assert property (!ce |=> st_ff == $past(st_ff))
        else $error("state moved with clock enable low");

    c_bit_write: cover property (ce && bus_wr && bus_bit_op && bus_addr == `PDD_ADDR_DIR1);
    c_output_drive: cover property (port0_oe != `PDD_ZERO ##1 ce && bus_rd && bus_addr == `PDD_ADDR_DAT0);
    c_analog_read: cover property (ce && bus_rd && bus_addr == `PDD_ADDR_DAT1 && (ana1 & st_ff.dir1) != `PDD_ZERO);
    c_reset_pin: cover property (ce && bus_rd && bus_addr == `PDD_ADDR_IN12 && reset_pin_select);

endmodule // pdd_port_regs

// file: sim/pdd_pin_model.sv
/*
 * Pins outside one bidirectional port.
 * Assumes out and oe come straight from the port registers.
 */
`timescale 1ns/1ps

module pdd_pin_model (
    input  wire logic       clk,
    input  wire logic [7:0] out,
    input  wire logic [7:0] oe,
    input  wire logic [7:0] ext,
    input  wire logic [7:0] ext_drv,
    output logic      [7:0] pin
);
    logic [7:0] float_ff = 8'h55;

    // Undriven bits flip every cycle so a stale level never passes for a real one
    always_ff @(posedge clk) float_ff <= ~float_ff;

    // Own buffer wins, then the outside driver, else the line floats
    always_comb pin = (oe & out) | (~oe & ext_drv & ext) | (~oe & ~ext_drv & float_ff);
endmodule // pdd_pin_model

// file: sim/pdd_port_regs_tb.sv
/*
 * Self-checking bench of the port direction/data registers.
 * Assumes one pin model on each bidirectional port.
 */
`timescale 1ns/1ps
`include "pdd_map.svh"

module pdd_port_regs_tb;
    localparam logic [7:0]  IMPL [3]   = '{`PDD_IMPL_0, `PDD_IMPL_1, `PDD_IMPL_4};
    localparam logic [19:0] ADDRS [10] = '{`PDD_ADDR_DAT0, `PDD_ADDR_DAT1, `PDD_ADDR_DAT4,
        `PDD_ADDR_IN12, `PDD_ADDR_IN13, `PDD_ADDR_DIR0, `PDD_ADDR_DIR1, `PDD_ADDR_DIR4,
        20'hf_ff02, 20'hf_ff30};

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic        bus_bit_op = 1'b0;
    logic [2:0]  bus_bit_idx = 3'h0;
    logic [19:0] bus_addr = 20'h0_0000;
    logic [7:0]  bus_wdata = 8'h00;
    logic [7:0]  bus_rdata;
    logic        rpin = 1'b1;
    logic        tpin = 1'b0;
    logic        rsel = 1'b0;
    logic        pue12 = 1'b0;
    logic        pu12;
    logic        rd_seen = 1'b0;
    logic [7:0]  drv = 8'hff;
    logic [7:0]  asb0 = 8'h00;
    logic [7:0]  asb1 = 8'h00;
    logic [7:0]  ext [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0]  pue [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0]  osb [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0]  ed [3] = '{8'hff, 8'hff, 8'hff};
    logic [7:0]  el [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0]  pin [3];
    logic [7:0]  pout [3];
    logic [7:0]  poe [3];
    logic [7:0]  pu [3];
    logic [7:0]  expq [$];
    logic [7:0]  rd_d;
    logic [2:0]  rix;
    logic [1:0]  wr_rd;
    int          ai;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          seed;

    ////////////////////////////////////////
    // Clock of 5 ns
    always #2.5 clk = ~clk;

    pdd_port_regs u_dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_bit_op(bus_bit_op), .bus_bit_idx(bus_bit_idx), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .port0_in(pin[0]), .port1_in(pin[1]), .port4_in(pin[2]), .reset_shared_pin(rpin),
        .timer_interrupt_input_pin(tpin), .reset_pin_select(rsel),
        .analog_select_bit0(asb0), .analog_select_bit1(asb1), .pullup_enable_bit0(pue[0]),
        .pullup_enable_bit1(pue[1]), .pullup_enable_bit4(pue[2]), .pullup_enable_bit12(pue12),
        .output_style_bit0(osb[0]), .output_style_bit1(osb[1]), .port0_out(pout[0]),
        .port1_out(pout[1]), .port4_out(pout[2]), .port0_oe(poe[0]), .port1_oe(poe[1]),
        .port4_oe(poe[2]), .pullup_on0(pu[0]), .pullup_on1(pu[1]), .pullup_on4(pu[2]),
        .pullup_on12(pu12)
    );

    // One pin model per bidirectional port
    for (genvar g = 0; g < 3; g++)
    begin : g_pin
        pdd_pin_model u_pin (.clk(clk), .out(pout[g]), .oe(poe[g]), .ext(ext[g]), .ext_drv(drv), .pin(pin[g]));
    end

    ////////////////////////////////////////
    // Expected values, kept in a shadow of the registers
    function automatic int pidx(input int a);
        return (a < 3) ? a : (a >= 5 && a < 8) ? a - 5 : -1;
    endfunction

    function automatic logic [7:0] ana(input int p);
        return (p == 0) ? (asb0 & `PDD_ANA_0) : (p == 1) ? (asb1 & `PDD_ANA_1) : 8'h00;
    endfunction

    function automatic logic [7:0] exp_rd(input int a);
        int p;
        p = pidx(a);
        if (a == 3) return (rpin | rsel) ? 8'h20 : 8'h00;
        if (a == 4) return tpin ? 8'h80 : 8'h00;
        if (p < 0) return 8'h00;
        if (a >= 5) return ed[p];
        return ((ed[p] & ~ana(p) & ext[p]) | (~ed[p] & el[p])) & IMPL[p];
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (expq.size() != 0) n_mismatch++;
        $display("samples_checked=%0d n_mismatch=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Strobes stay up between calls, so back-to-back accesses need no idle edge
    task automatic acc(input logic w, input logic r, input int a, input logic bo, input logic [2:0] ix,
                       input logic [7:0] d);
        int         p;
        logic [7:0] nv;
        p = pidx(a);
        @(posedge clk);
        bus_wr      <= w;
        bus_rd      <= r;
        bus_addr    <= ADDRS[a];
        bus_bit_op  <= bo;
        bus_bit_idx <= ix;
        bus_wdata   <= d;
        if (r && ce) expq.push_back(exp_rd(a));
        if (w && ce && p >= 0)
        begin
            nv = (a >= 5) ? ed[p] : el[p];
            if (bo) nv[ix] = d[0];
            else nv = d;
            if (a >= 5) ed[p] = nv | ~IMPL[p];
            else el[p] = nv & IMPL[p];
        end
    endtask

    task automatic idle();
        @(posedge clk);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        @(negedge clk);
    endtask

    task automatic pchk(input int p);
        check(pout[p], el[p]);
        check(poe[p], ~ed[p]);
        check(pin[p] & poe[p], el[p] & ~ed[p]);
        check(pu[p], pue[p] & ed[p] & ~ana(p) & ~osb[p] & IMPL[p]);
        check({7'h00, pu12}, {7'h00, pue12 | rsel});
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        ext   <= '{8'hff, 8'hff, 8'hff};
        pue   <= '{8'h00, 8'h00, 8'h00};
        asb0  <= 8'h80;
        asb1  <= 8'h00;
        {rpin, tpin, rsel, pue12} <= 4'h8;
        repeat (11) @(posedge clk);
        rst_n <= 1'b1;
        ed = '{8'hff, 8'hff, 8'hff};
        el = '{8'h00, 8'h00, 8'h00};
        @(negedge clk);
        for (int p = 0; p < 3; p++) pchk(p);
    endtask

    ////////////////////////////////////////
    // Read data lands one cycle after the read is taken
    always @(posedge clk) rd_seen <= bus_rd & ce & rst_n;

    always @(negedge clk)
        if (rd_seen)
        begin
            if (expq.size() == 0) n_mismatch++;
            else check(bus_rdata, expq.pop_front());
        end

    // A hang ends in the closing report
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results();
    end

    initial
    begin
        seed = 32'h92e4;
        do_reset();
        // Every place after reset, two unmapped ones among them
        for (int i = 0; i < 10; i++) acc(0, 1, i, 0, 0, 8'h00);
        // Direction goes out first, so the pin drives the reset latch level for one cycle before a5
        acc(1, 1, 5, 0, 0, 8'h00);
        acc(1, 0, 0, 0, 0, 8'ha5);
        acc(0, 1, 0, 0, 0, 8'h00);
        acc(1, 0, 5, 1, 7, 8'h01);
        acc(0, 1, 0, 0, 0, 8'h00);
        idle();
        @(posedge clk);
        rsel <= 1'b1;
        rpin <= 1'b0;
        tpin <= 1'b1;
        acc(0, 1, 3, 0, 0, 8'h00);
        acc(0, 1, 4, 0, 0, 8'h00);
        // Fixed bits and the input-only place ignore writes
        acc(1, 0, 7, 0, 0, 8'h00);
        acc(1, 0, 2, 0, 0, 8'hff);
        acc(1, 0, 3, 0, 0, 8'hff);
        acc(0, 1, 7, 0, 0, 8'h00);
        acc(0, 1, 2, 0, 0, 8'h00);
        acc(0, 1, 3, 0, 0, 8'h00);
        idle();
        // With the clock enable low nothing is taken
        @(posedge clk);
        ce <= 1'b0;
        acc(1, 1, 6, 0, 0, 8'h80);
        idle();
        @(posedge clk);
        ce <= 1'b1;
        acc(0, 1, 6, 0, 0, 8'h00);
        // All implemented port 1 bits to output, then the latch is what reads back
        acc(1, 0, 6, 0, 0, 8'h00);
        acc(1, 1, 1, 0, 0, 8'h5a);
        acc(0, 1, 1, 0, 0, 8'h00);
        idle();
        for (int p = 0; p < 3; p++) pchk(p);
        do_reset();
        // Random traffic; fixed bits written at their reset values
        for (int k = 0; k < 400; k++)
        begin
            if (k % 16 == 0)
            begin
                idle();
                for (int p = 0; p < 3; p++) pchk(p);
                @(posedge clk);
                for (int p = 0; p < 3; p++)
                begin
                    ext[p] <= 8'($random(seed));
                    pue[p] <= 8'($random(seed)) & IMPL[p];
                    osb[p] <= (p < 2) ? 8'($random(seed)) : 8'h00;
                end
                asb0 <= 8'($random(seed));
                asb1 <= 8'($random(seed));
                {rpin, tpin, rsel, pue12} <= 4'($random(seed));
            end
            ai = {$random(seed)} % 10;
            rd_d = 8'($random(seed));
            rix = 3'($random(seed));
            wr_rd = 2'($random(seed));
            if (pidx(ai) >= 0 && ai >= 5) rd_d = rd_d | ~IMPL[pidx(ai)];
            if (pidx(ai) >= 0 && ai < 5) rd_d = rd_d & IMPL[pidx(ai)];
            if (pidx(ai) >= 0 && !IMPL[pidx(ai)][rix]) rd_d[0] = (ai >= 5);
            acc(wr_rd[0], wr_rd[1], ai, rd_d[7], rix, rd_d);
        end
        idle();
        for (int p = 0; p < 3; p++) pchk(p);
        results();
    end
endmodule // pdd_port_regs_tb
